// [common/mup_pkg.sv]
// Purpose: constants for the motion unit offset and interpolation parameter bank
// Assumes: Avalon-MM byte addresses, register index times four gives the byte address
// Notes: indices below 0x60c5 mirror object numbers, the rest sit in a free range
package mup_pkg;
   // register indices, byte address is index * 4
   localparam logic [14:0] IDX_VEL_UNIT = 15'h60a9;
   localparam logic [14:0] IDX_POS_OFF = 15'h60b0;
   localparam logic [14:0] IDX_SPD_OFF = 15'h60b1;
   localparam logic [14:0] IDX_TRQ_OFF = 15'h60b2;
   localparam logic [14:0] IDX_SETPOINT = 15'h60c1;
   localparam logic [14:0] IDX_INTERP_TIME = 15'h60c2;
   localparam logic [14:0] IDX_BUF_MAX = 15'h60c4;
   localparam logic [14:0] IDX_BUF_ACT = 15'h6100;
   localparam logic [14:0] IDX_BUF_ORG = 15'h6101;
   localparam logic [14:0] IDX_BUF_POS = 15'h6102;
   localparam logic [14:0] IDX_REC_SIZE = 15'h6103;
   localparam logic [14:0] IDX_BUF_CLEAR = 15'h6104;
   localparam logic [14:0] IDX_STATUS = 15'h6105;
   // velocity unit word fields
   localparam int VEL_TIME_LSB = 8;
   localparam int VEL_POS_LSB = 16;
   localparam int VEL_EXP_LSB = 24;
   localparam logic [7:0] VEL_RSVD_MASK = 8'h00;
   // interpolation time register fields
   localparam int ITP_VAL_LSB = 0;
   localparam int ITP_EXP_LSB = 8;
   // reset values
   localparam logic [31:0] RST_VEL_UNIT = 32'h00b44700;
   localparam logic [31:0] RST_OFFSET = 32'h00000000;
   localparam logic [15:0] RST_TRQ_OFF = 16'h0000;
   localparam logic [7:0] RST_ITP_VAL = 8'h01;
   localparam logic [7:0] RST_ITP_EXP = 8'hfd;
   localparam logic [31:0] RST_BUF_MAX = 32'h00000001;
   localparam logic [31:0] RST_BUF_ACT = 32'h00000001;
   localparam logic [7:0] RST_BUF_ORG = 8'h00;
   localparam logic [15:0] RST_BUF_POS = 16'h0001;
   localparam logic [7:0] RST_REC_SIZE = 8'h04;
   // buffer organization and clear codes
   localparam logic [7:0] ORG_FIFO = 8'h00;
   localparam logic [7:0] ORG_RING = 8'h01;
   localparam logic [7:0] CLR_DISCARD = 8'h00;
   localparam logic [7:0] CLR_ENABLE = 8'h01;
   // interpolation exponents and microsecond scale factors
   localparam logic [7:0] EXP_MILLI = 8'hfd;
   localparam logic [7:0] EXP_M4 = 8'hfc;
   localparam logic [7:0] EXP_M5 = 8'hfb;
   localparam logic [7:0] EXP_MICRO = 8'hfa;
   localparam logic [9:0] US_PER_MS = 10'd1000;
   localparam logic [9:0] US_PER_E4 = 10'd100;
   localparam logic [9:0] US_PER_E5 = 10'd10;
   localparam logic [9:0] US_PER_E6 = 10'd1;
endpackage

// [hdl/mup_param_bank.sv]
// Purpose: parameter bank for offsets, velocity units and interpolation setup
// Assumes: Avalon-MM slave, byte addresses, one wait state per access
// Notes: sync and store strobes come from logic on the same clock
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps

// Overview of operation
// - velocity time unit in bits 8-15
// - velocity position unit in bits 16-23
// - velocity power-of-ten exponent in bits 24-31
// - signed 32-bit position offset, default zero
// - signed 32-bit speed offset, default zero
// - signed 16-bit torque offset, tenth percent
// - first set-point adopted at next sync
// - cycle time is period times ten-power exponent
// - buffer config: max size, organization, size, clear
// - buffer config records next storage position
// - organization zero is FIFO, one is ring
// - clear zero discards and disables, one enables
module mup_param_bank
   import mup_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RESET_I,
   input wire logic [16:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic SYNC_I,
   input wire logic REC_STORE_I,
   output logic [7:0] VEL_TIME_UNIT_O,
   output logic [7:0] VEL_POS_UNIT_O,
   output logic [7:0] VEL_EXP_O,
   output logic [31:0] POS_OFFSET_O,
   output logic [31:0] SPEED_OFFSET_O,
   output logic [15:0] TORQUE_OFFSET_O,
   output logic [31:0] SETPOINT_O,
   output logic [19:0] CYCLE_US_O,
   output logic CYCLE_ERR_O,
   output logic BUF_ENABLE_O,
   output logic BUF_RING_O,
   output logic [15:0] BUF_POS_O,
   output logic [7:0] REC_SIZE_O
);

   // merge write data into an old value under byte enables
   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // true when the bus address selects a register index
   function automatic logic hit(input logic [16:0] addr, input logic [14:0] idx);
      return addr[16:2] == idx;
   endfunction

   logic wait_reg;
   logic [31:0] rdata_reg;
   logic [31:0] vel_reg;
   logic [31:0] pos_off_reg;
   logic [31:0] spd_off_reg;
   logic [15:0] trq_off_reg;
   logic [31:0] sp_pend_reg;
   logic [31:0] sp_act_reg;
   logic [7:0] itp_val_reg;
   logic [7:0] itp_exp_reg;
   logic [19:0] cyc_reg;
   logic cyc_err_reg;
   logic [31:0] buf_act_reg;
   logic [7:0] buf_org_reg;
   logic [15:0] buf_pos_reg;
   logic [7:0] rec_size_reg;
   logic buf_ring_reg;
   logic buf_en_reg;
   logic wr_go;
   logic rd_go;
   logic [31:0] rdata_next;
   logic [31:0] vel_next;
   logic [15:0] pos_next;

   // a write completes on the edge where waitrequest is seen low, a read is captured one edge earlier
   assign wr_go = AVS_WRITE_I && !wait_reg;
   assign rd_go = AVS_READ_I && wait_reg;

   // one wait state, then a single low cycle of waitrequest
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= !((AVS_READ_I || AVS_WRITE_I) && wait_reg);
      end
   end

   // read mux, unmapped and write-only indices read zero
   always_comb begin
      rdata_next = 32'h00000000;
      if (hit(AVS_ADDRESS_I, IDX_VEL_UNIT)) rdata_next = vel_reg;
      if (hit(AVS_ADDRESS_I, IDX_POS_OFF)) rdata_next = pos_off_reg;
      if (hit(AVS_ADDRESS_I, IDX_SPD_OFF)) rdata_next = spd_off_reg;
      if (hit(AVS_ADDRESS_I, IDX_TRQ_OFF)) rdata_next = {16'h0000, trq_off_reg};
      if (hit(AVS_ADDRESS_I, IDX_SETPOINT)) rdata_next = sp_pend_reg;
      if (hit(AVS_ADDRESS_I, IDX_INTERP_TIME)) rdata_next = {16'h0000, itp_exp_reg, itp_val_reg};
      if (hit(AVS_ADDRESS_I, IDX_BUF_MAX)) rdata_next = RST_BUF_MAX;
      if (hit(AVS_ADDRESS_I, IDX_BUF_ACT)) rdata_next = buf_act_reg;
      if (hit(AVS_ADDRESS_I, IDX_BUF_ORG)) rdata_next = {24'h000000, buf_org_reg};
      if (hit(AVS_ADDRESS_I, IDX_BUF_POS)) rdata_next = {16'h0000, buf_pos_reg};
      if (hit(AVS_ADDRESS_I, IDX_STATUS)) rdata_next = {30'h00000000, cyc_err_reg, buf_en_reg};
   end

   // read data captured as waitrequest drops and held until the next read
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         rdata_reg <= 32'h00000000;
      end else if (rd_go) begin
         rdata_reg <= rdata_next;
      end
   end

   // velocity unit word, low byte forced to zero
   assign vel_next = be_merge(vel_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         vel_reg <= RST_VEL_UNIT;
      end else if (wr_go && hit(AVS_ADDRESS_I, IDX_VEL_UNIT)) begin
         vel_reg <= {vel_next[31:8], VEL_RSVD_MASK};
      end
   end

   // set value offsets
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         pos_off_reg <= RST_OFFSET;
         spd_off_reg <= RST_OFFSET;
         trq_off_reg <= RST_TRQ_OFF;
      end else if (wr_go) begin
         if (hit(AVS_ADDRESS_I, IDX_POS_OFF)) begin
            pos_off_reg <= be_merge(pos_off_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end
         if (hit(AVS_ADDRESS_I, IDX_SPD_OFF)) begin
            spd_off_reg <= be_merge(spd_off_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end
         if (hit(AVS_ADDRESS_I, IDX_TRQ_OFF)) begin
            trq_off_reg <= 16'(be_merge({16'h0000, trq_off_reg}, AVS_WRITEDATA_I,
                                        AVS_BYTEENABLE_I));
         end
      end
   end

   // first set-point: written value waits, adopted on sync
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         sp_pend_reg <= RST_OFFSET;
         sp_act_reg <= RST_OFFSET;
      end else begin
         if (wr_go && hit(AVS_ADDRESS_I, IDX_SETPOINT)) begin
            sp_pend_reg <= be_merge(sp_pend_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end
         if (SYNC_I) begin
            sp_act_reg <= sp_pend_reg;
         end
      end
   end

   // interpolation period value and exponent
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         itp_val_reg <= RST_ITP_VAL;
         itp_exp_reg <= RST_ITP_EXP;
      end else if (wr_go && hit(AVS_ADDRESS_I, IDX_INTERP_TIME)) begin
         if (AVS_BYTEENABLE_I[0]) itp_val_reg <= AVS_WRITEDATA_I[ITP_VAL_LSB +: 8];
         if (AVS_BYTEENABLE_I[1]) itp_exp_reg <= AVS_WRITEDATA_I[ITP_EXP_LSB +: 8];
      end
   end

   // cycle time in microseconds, flags exponents outside the supported range
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         cyc_reg <= 20'h00000;
         cyc_err_reg <= 1'b0;
      end else begin
         cyc_err_reg <= 1'b0;
         case (itp_exp_reg)
            EXP_MILLI: cyc_reg <= 20'(itp_val_reg * US_PER_MS);
            EXP_M4: cyc_reg <= 20'(itp_val_reg * US_PER_E4);
            EXP_M5: cyc_reg <= 20'(itp_val_reg * US_PER_E5);
            EXP_MICRO: cyc_reg <= 20'(itp_val_reg * US_PER_E6);
            default: begin
               cyc_reg <= 20'h00000;
               cyc_err_reg <= 1'b1;
            end
         endcase
      end
   end

   // buffer configuration entries written by software
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         buf_act_reg <= RST_BUF_ACT;
         buf_org_reg <= RST_BUF_ORG;
         buf_ring_reg <= (RST_BUF_ORG == ORG_RING);
         rec_size_reg <= RST_REC_SIZE;
      end else if (wr_go) begin
         if (hit(AVS_ADDRESS_I, IDX_BUF_ACT)) begin
            buf_act_reg <= be_merge(buf_act_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end
         if (hit(AVS_ADDRESS_I, IDX_BUF_ORG) && AVS_BYTEENABLE_I[0]) begin
            buf_org_reg <= AVS_WRITEDATA_I[7:0];
            buf_ring_reg <= (AVS_WRITEDATA_I[7:0] == ORG_RING);
         end
         if (hit(AVS_ADDRESS_I, IDX_REC_SIZE) && AVS_BYTEENABLE_I[0]) begin
            rec_size_reg <= AVS_WRITEDATA_I[7:0];
         end
      end
   end

   // buffer access enable from the clear entry, other codes ignored
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         buf_en_reg <= 1'b0;
      end else if (wr_go && hit(AVS_ADDRESS_I, IDX_BUF_CLEAR) && AVS_BYTEENABLE_I[0]) begin
         if (AVS_WRITEDATA_I[7:0] == CLR_DISCARD) buf_en_reg <= 1'b0;
         if (AVS_WRITEDATA_I[7:0] == CLR_ENABLE) buf_en_reg <= 1'b1;
      end
   end

   // next free entry: FIFO stops at the size, ring wraps to the first entry
   always_comb begin
      pos_next = buf_pos_reg;
      if (buf_org_reg == ORG_RING) begin
         pos_next = ({16'h0000, buf_pos_reg} >= buf_act_reg) ? RST_BUF_POS
                                                            : 16'(buf_pos_reg + 16'h0001);
      end else if ({16'h0000, buf_pos_reg} < buf_act_reg) begin
         pos_next = 16'(buf_pos_reg + 16'h0001);
      end
   end

   // storage position: clear and software writes take priority over a store
   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         buf_pos_reg <= RST_BUF_POS;
      end else if (wr_go && hit(AVS_ADDRESS_I, IDX_BUF_CLEAR) && AVS_BYTEENABLE_I[0]
                   && AVS_WRITEDATA_I[7:0] == CLR_DISCARD) begin
         buf_pos_reg <= RST_BUF_POS;
      end else if (wr_go && hit(AVS_ADDRESS_I, IDX_BUF_POS)) begin
         buf_pos_reg <= 16'(be_merge({16'h0000, buf_pos_reg}, AVS_WRITEDATA_I,
                                     AVS_BYTEENABLE_I));
      end else if (REC_STORE_I && buf_en_reg) begin
         buf_pos_reg <= pos_next;
      end
   end

   // outputs straight from registers
   assign AVS_READDATA_O = rdata_reg;
   assign AVS_WAITREQUEST_O = wait_reg;
   assign VEL_TIME_UNIT_O = vel_reg[VEL_TIME_LSB +: 8];
   assign VEL_POS_UNIT_O = vel_reg[VEL_POS_LSB +: 8];
   assign VEL_EXP_O = vel_reg[VEL_EXP_LSB +: 8];
   assign POS_OFFSET_O = pos_off_reg;
   assign SPEED_OFFSET_O = spd_off_reg;
   assign TORQUE_OFFSET_O = trq_off_reg;
   assign SETPOINT_O = sp_act_reg;
   assign CYCLE_US_O = cyc_reg;
   assign CYCLE_ERR_O = cyc_err_reg;
   assign BUF_ENABLE_O = buf_en_reg;
   assign BUF_RING_O = buf_ring_reg;
   assign BUF_POS_O = buf_pos_reg;
   assign REC_SIZE_O = rec_size_reg;

   // checks on register and buffer behaviour
   chk_time_unit_wr: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_go && hit(AVS_ADDRESS_I, IDX_VEL_UNIT) && AVS_BYTEENABLE_I[1]
      |=> VEL_TIME_UNIT_O == $past(AVS_WRITEDATA_I[15:8]))
      else $error("time unit not stored from bits 15:8");
   chk_pos_unit_wr: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_go && hit(AVS_ADDRESS_I, IDX_VEL_UNIT) && AVS_BYTEENABLE_I[2]
      |=> VEL_POS_UNIT_O == $past(AVS_WRITEDATA_I[23:16]))
      else $error("position unit not stored from bits 23:16");
   chk_vel_exp_wr: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_go && hit(AVS_ADDRESS_I, IDX_VEL_UNIT) && AVS_BYTEENABLE_I[3]
      |=> VEL_EXP_O == $past(AVS_WRITEDATA_I[31:24]))
      else $error("velocity exponent not stored from bits 31:24");
   chk_pos_offset_wr: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_go && hit(AVS_ADDRESS_I, IDX_POS_OFF) && AVS_BYTEENABLE_I == 4'hf
      |=> POS_OFFSET_O == $past(AVS_WRITEDATA_I))
      else $error("position offset write lost");
   chk_speed_offset_wr: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_go && hit(AVS_ADDRESS_I, IDX_SPD_OFF) && AVS_BYTEENABLE_I == 4'hf
      |=> SPEED_OFFSET_O == $past(AVS_WRITEDATA_I))
      else $error("speed offset write lost");
   chk_torque_offset_wr: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_go && hit(AVS_ADDRESS_I, IDX_TRQ_OFF) && AVS_BYTEENABLE_I[1:0] == 2'h3
      |=> TORQUE_OFFSET_O == $past(AVS_WRITEDATA_I[15:0]))
      else $error("torque offset write lost");
   chk_setpoint_hold: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      !SYNC_I |=> $stable(SETPOINT_O))
      else $error("set-point changed without sync");
   chk_setpoint_sync: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      SYNC_I |=> SETPOINT_O == $past(sp_pend_reg))
      else $error("set-point not adopted at sync");
   chk_cycle_milli: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      itp_exp_reg == EXP_MILLI |=> CYCLE_US_O == 20'($past(itp_val_reg) * US_PER_MS))
      else $error("cycle time wrong for millisecond base");
   chk_ring_wrap: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      REC_STORE_I && buf_en_reg && !wr_go && BUF_RING_O
      && {16'h0000, buf_pos_reg} >= buf_act_reg |=> BUF_POS_O == RST_BUF_POS)
      else $error("ring buffer did not wrap");
   chk_clear_disable: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      wr_go && hit(AVS_ADDRESS_I, IDX_BUF_CLEAR) && AVS_BYTEENABLE_I[0]
      && AVS_WRITEDATA_I[7:0] == CLR_DISCARD |=> !BUF_ENABLE_O && BUF_POS_O == RST_BUF_POS)
      else $error("clear did not discard and disable");
   chk_vel_reserved: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      rd_go && hit(AVS_ADDRESS_I, IDX_VEL_UNIT) |=> AVS_READDATA_O[7:0] == 8'h00)
      else $error("reserved velocity bits read non-zero");
   chk_one_wait: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
      (AVS_READ_I || AVS_WRITE_I) && wait_reg |=> !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
      else $error("waitrequest did not drop for exactly one cycle");

endmodule

// [verif/mup_param_bank_tb.sv]
// Purpose: self-checking bench for the motion parameter bank
// Assumes: Avalon-MM master with one outstanding access, sync and store strobes from the bench
// Notes: random data from a fixed seed, corner cases mixed in
`timescale 1ns/10ps
module mup_param_bank_tb
   import mup_pkg::*;
;
   logic CLK_SYS_I, RESET_I, AVS_READ_I, AVS_WRITE_I, SYNC_I, REC_STORE_I;
   logic [16:0] AVS_ADDRESS_I;
   logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, POS_OFFSET_O, SPEED_OFFSET_O, SETPOINT_O;
   logic [3:0] AVS_BYTEENABLE_I;
   logic AVS_WAITREQUEST_O, CYCLE_ERR_O, BUF_ENABLE_O, BUF_RING_O;
   logic [7:0] VEL_TIME_UNIT_O, VEL_POS_UNIT_O, VEL_EXP_O, REC_SIZE_O;
   logic [15:0] TORQUE_OFFSET_O, BUF_POS_O;
   logic [19:0] CYCLE_US_O;
   int error_cnt = 0;
   int cmp_count = 0;
   integer seed;
   logic [31:0] rd, v, vel, spd;
   logic [15:0] pos;
   logic [7:0] per;
   logic [7:0] exps [6] = '{8'hfc, 8'hfb, 8'hfa, 8'h00, 8'h7f, 8'hfd};
   logic [14:0] offs [3] = '{IDX_POS_OFF, IDX_SPD_OFF, IDX_TRQ_OFF};

   mup_param_bank u_mup_param_bank (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I),
      .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
      .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
      .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
      .SYNC_I(SYNC_I), .REC_STORE_I(REC_STORE_I), .VEL_TIME_UNIT_O(VEL_TIME_UNIT_O),
      .VEL_POS_UNIT_O(VEL_POS_UNIT_O), .VEL_EXP_O(VEL_EXP_O), .POS_OFFSET_O(POS_OFFSET_O),
      .SPEED_OFFSET_O(SPEED_OFFSET_O), .TORQUE_OFFSET_O(TORQUE_OFFSET_O),
      .SETPOINT_O(SETPOINT_O), .CYCLE_US_O(CYCLE_US_O), .CYCLE_ERR_O(CYCLE_ERR_O),
      .BUF_ENABLE_O(BUF_ENABLE_O), .BUF_RING_O(BUF_RING_O), .BUF_POS_O(BUF_POS_O),
      .REC_SIZE_O(REC_SIZE_O));

   // free-running system clock
   initial begin
      CLK_SYS_I = 1'b0;
      forever #5 CLK_SYS_I = ~CLK_SYS_I;
   end

   // one access: hold the request until waitrequest is sampled low, then release
   task automatic bus_access(input logic is_rd, input logic [14:0] idx, input logic [31:0] wd,
                             input logic [3:0] be, output logic [31:0] data);
      @(posedge CLK_SYS_I);
      AVS_ADDRESS_I <= {idx, 2'b00};
      AVS_READ_I <= is_rd;
      AVS_WRITE_I <= !is_rd;
      AVS_WRITEDATA_I <= wd;
      AVS_BYTEENABLE_I <= be;
      // only the watchdog ends a wait that never completes
      do begin
         @(posedge CLK_SYS_I);
      end while (AVS_WAITREQUEST_O !== 1'b0);
      data = AVS_READDATA_O;
      AVS_READ_I <= 1'b0;
      AVS_WRITE_I <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [14:0] idx, input logic [31:0] wd);
      logic [31:0] d;
      bus_access(1'b0, idx, wd, 4'hf, d);
   endtask

   // compare a value read over the bus
   task automatic chk_reg(input logic [14:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      bus_access(1'b1, idx, 32'h0, 4'h0, d);
      cmp_count++;
      if (d !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: read idx %h got %h expected %h", $time, idx, d, exp);
      end
   endtask

   // compare a value seen on an output port
   task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: port got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle strobe on sync or record store
   task automatic pulse(input logic is_sync);
      @(posedge CLK_SYS_I);
      SYNC_I <= is_sync;
      REC_STORE_I <= !is_sync;
      @(posedge CLK_SYS_I);
      SYNC_I <= 1'b0;
      REC_STORE_I <= 1'b0;
      #1;
   endtask

   // expected {error, microseconds} for a period and exponent
   function automatic logic [20:0] exp_cycle(input logic [7:0] p, input logic [7:0] e);
      case (e)
         8'hfd: return {1'b0, 12'h0, p} * 21'd1000;
         8'hfc: return {1'b0, 12'h0, p} * 21'd100;
         8'hfb: return {1'b0, 12'h0, p} * 21'd10;
         8'hfa: return {13'h0, p};
         default: return {1'b1, 20'h0};
      endcase
   endfunction

   // next storage position after one stored record
   function automatic logic [15:0] next_pos(input logic [15:0] p, input logic ring,
                                            input logic [15:0] size);
      if (p < size) return p + 16'h1;
      return ring ? 16'h1 : p;
   endfunction

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      #200000;
      error_cnt++;
      complete_run();
   end

   // main sequence
   initial begin
      seed = 32'h12fd;
      RESET_I = 1'b1;
      {AVS_READ_I, AVS_WRITE_I, SYNC_I, REC_STORE_I} = 4'h0;
      AVS_ADDRESS_I = 17'h0;
      AVS_WRITEDATA_I = 32'h0;
      AVS_BYTEENABLE_I = 4'h0;
      repeat (3) @(posedge CLK_SYS_I);
      RESET_I <= 1'b0;
      @(posedge CLK_SYS_I);
      #1;
      chk_out(CYCLE_US_O, 32'd1000);
      chk_reg(IDX_VEL_UNIT, 32'h00b44700);
      chk_out({VEL_EXP_O, VEL_POS_UNIT_O, VEL_TIME_UNIT_O, 8'h00}, 32'h00b44700);
      chk_reg(IDX_POS_OFF, 32'h0);
      chk_reg(IDX_SPD_OFF, 32'h0);
      chk_reg(IDX_TRQ_OFF, 32'h0);
      chk_reg(IDX_SETPOINT, 32'h0);
      chk_reg(IDX_INTERP_TIME, 32'h0000fd01);
      chk_reg(IDX_BUF_MAX, 32'h1);
      chk_reg(IDX_BUF_POS, 32'h1);
      chk_reg(15'h0100, 32'h0);
      // velocity word: random full writes, then a single-lane write
      repeat (4) begin
         vel = $random(seed);
         wr(IDX_VEL_UNIT, vel);
         chk_reg(IDX_VEL_UNIT, {vel[31:8], 8'h00});
         chk_out({VEL_EXP_O, VEL_POS_UNIT_O, VEL_TIME_UNIT_O}, {8'h0, vel[31:8]});
      end
      v = $random(seed);
      bus_access(1'b0, IDX_VEL_UNIT, v, 4'b0100, rd);
      chk_out(VEL_POS_UNIT_O, {24'h0, v[23:16]});
      chk_out({VEL_EXP_O, VEL_TIME_UNIT_O}, {16'h0, vel[31:24], vel[15:8]});
      // signed offsets with random and extreme values
      foreach (offs[i]) begin
         v = (i == 2) ? 32'hffff8000 : $random(seed);
         wr(offs[i], v);
         if (i == 0) rd = v;
         if (i == 1) spd = v;
         chk_reg(offs[i], (i == 2) ? {16'h0, v[15:0]} : v);
      end
      chk_out(POS_OFFSET_O, rd);
      chk_out(SPEED_OFFSET_O, spd);
      wr(IDX_POS_OFF, 32'h80000000);
      chk_out(POS_OFFSET_O, 32'h80000000);
      chk_out(TORQUE_OFFSET_O, 32'h8000);
      // set-point waits for the sync instant
      v = $random(seed);
      wr(IDX_SETPOINT, v);
      chk_out(SETPOINT_O, 32'h0);
      chk_reg(IDX_SETPOINT, v);
      pulse(1'b1);
      chk_out(SETPOINT_O, v);
      // interpolation time over every supported exponent and two unsupported ones
      foreach (exps[i]) begin
         per = $random(seed);
         wr(IDX_INTERP_TIME, {16'h0, exps[i], per});
         chk_reg(IDX_INTERP_TIME, {16'h0, exps[i], per});
         @(posedge CLK_SYS_I);
         #1;
         chk_out({CYCLE_ERR_O, CYCLE_US_O}, exp_cycle(per, exps[i]));
      end
      // buffer configuration in both organizations
      wr(IDX_BUF_ACT, 32'h3);
      chk_reg(IDX_BUF_ACT, 32'h3);
      v = $random(seed);
      wr(IDX_REC_SIZE, {24'h0, v[7:0]});
      chk_out(REC_SIZE_O, {24'h0, v[7:0]});
      chk_reg(IDX_REC_SIZE, 32'h0);
      for (int org = 0; org < 2; org++) begin
         wr(IDX_BUF_ORG, org);
         chk_out(BUF_RING_O, org);
         wr(IDX_BUF_CLEAR, {24'h0, CLR_DISCARD});
         chk_out({BUF_ENABLE_O, BUF_POS_O}, 32'h1);
         pulse(1'b0);
         chk_out(BUF_POS_O, 32'h1);
         wr(IDX_BUF_CLEAR, {24'h0, CLR_ENABLE});
         wr(IDX_BUF_CLEAR, 32'h2);
         chk_out(BUF_ENABLE_O, 32'h1);
         chk_reg(IDX_STATUS, 32'h1);
         pos = 16'h1;
         repeat (4) begin
            pulse(1'b0);
            pos = next_pos(pos, org[0], 16'h3);
            chk_out(BUF_POS_O, {16'h0, pos});
         end
         chk_reg(IDX_BUF_POS, {16'h0, pos});
      end
      // software places the storage position directly
      wr(IDX_BUF_POS, 32'h2);
      chk_out(BUF_POS_O, 32'h2);
      chk_reg(IDX_BUF_POS, 32'h2);
      complete_run();
   end
endmodule
